//--- common/jk_pkg.sv
// Constants and types shared by the dual J-K storage block.
// Assumes a single 100 MHz core clock and pins sampled through synchronisers.
// How it works
// - Two elements, each with its own inputs
// - State changes on own falling clock or while a preset or clear force is held
// - Hold, clear, set or toggle from requests
// - Requests read only in the cycle the fall is seen, committed then
package jk_pkg;

   localparam int ELEM_COUNT = 2;
   localparam int SYNC_DEPTH = 2;
   localparam int CLK_PERIOD_NS = 10;
   localparam logic STATE_RESET = 1'h0;
   localparam logic CLK_PREV_RESET = 1'h0;
   localparam logic ACTIVE_LOW_IDLE = 1'h1;

   // Bit positions of one element's pins inside the idle-level word PIN_IDLE
   localparam int PIN_CLK = 0;
   localparam int PIN_SET = 1;
   localparam int PIN_RST = 2;
   localparam int PIN_PRESET_N = 3;
   localparam int PIN_CLEAR_N = 4;
   localparam int PIN_COUNT = 5;

   typedef enum logic [1:0] {
      MODE_HOLD,
      MODE_CLEAR,
      MODE_SET,
      MODE_TOGGLE
   } jk_mode_t;

   function automatic jk_mode_t decode_mode(input logic set_req, input logic rst_req);
      jk_mode_t m;
      m = MODE_HOLD;
      case ({set_req, rst_req})
         2'h0: m = MODE_HOLD;
         2'h1: m = MODE_CLEAR;
         2'h2: m = MODE_SET;
         default: m = MODE_TOGGLE;
      endcase
      return m;
   endfunction

endpackage

//--- common/jk_elem_if.sv
// Per-element link between the pin front end and one storage element.
// Assumes all signals are already in the core clock domain.
`timescale 1ns/1ps
interface jk_elem_if;
   logic fall;
   logic set_req;
   logic rst_req;
   logic preset;
   logic clear;
   logic previous_state;

   modport front (output fall, output set_req, output rst_req, output preset, output clear,
                  input previous_state);
   modport elem (input fall, input set_req, input rst_req, input preset, input clear,
                 output previous_state);
endinterface

//--- rtl/jk_element.sv
// One J-K storage element acting on a detected falling clock edge.
// Assumes the front end delivers synchronised, one-cycle edge pulses.
`timescale 1ns/1ps
module jk_element
   import jk_pkg::*;
(
   input wire logic core_clk,
   input wire logic resetn,
   jk_elem_if.elem link
);

   logic state_q;
   logic state_d;
   jk_mode_t mode;

   always_comb begin
      mode = decode_mode(link.set_req, link.rst_req);
      state_d = state_q;
      // Preset dominates if both forces are held together
      if (link.preset) begin
         state_d = 1'h1;
      end else if (link.clear) begin
         state_d = 1'h0;
      end else if (link.fall) begin
         case (mode)
            MODE_HOLD: state_d = state_q;
            MODE_CLEAR: state_d = 1'h0;
            MODE_SET: state_d = 1'h1;
            MODE_TOGGLE: state_d = ~state_q;
            default: state_d = state_q;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= STATE_RESET;
      end else begin
         state_q <= state_d;
      end
   end

   assign link.previous_state = state_q;

endmodule

//--- rtl/dual_jk_flipflop.sv
// Top of the dual J-K storage block: pin synchronisers, edge detect, two elements.
// Assumes element clocks are far slower than core_clk so every level is seen.
`timescale 1ns/1ps
module dual_jk_flipflop
   import jk_pkg::*;
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [ELEM_COUNT-1:0] elem_clk,
   input wire logic [ELEM_COUNT-1:0] set_req,
   input wire logic [ELEM_COUNT-1:0] rst_req,
   input wire logic [ELEM_COUNT-1:0] preset_n,
   input wire logic [ELEM_COUNT-1:0] clear_n,
   output logic [ELEM_COUNT-1:0] state
);

   // Idle pin levels: clocks and requests low, forces released
   localparam logic [PIN_COUNT-1:0] PIN_IDLE = {ACTIVE_LOW_IDLE, ACTIVE_LOW_IDLE, 1'h0, 1'h0, 1'h0};

   // First element: two stages per pin, then clock history
   logic clk0_meta_q;
   logic clk0_sync_q;
   logic clk0_prev_q;
   logic set0_meta_q;
   logic set0_sync_q;
   logic rst0_meta_q;
   logic rst0_sync_q;
   logic preset_n0_meta_q;
   logic preset_n0_sync_q;
   logic clear_n0_meta_q;
   logic clear_n0_sync_q;
   logic state0_q;

   // Second element: same structure, fully separate
   logic clk1_meta_q;
   logic clk1_sync_q;
   logic clk1_prev_q;
   logic set1_meta_q;
   logic set1_sync_q;
   logic rst1_meta_q;
   logic rst1_sync_q;
   logic preset_n1_meta_q;
   logic preset_n1_sync_q;
   logic clear_n1_meta_q;
   logic clear_n1_sync_q;
   logic state1_q;

   jk_elem_if link0 ();
   jk_elem_if link1 ();

   // Pins are outside the core clock; only the second stage is ever read
   // Same depth on every pin keeps a clock and its requests aligned
   // Clock highs or lows shorter than one core cycle can be missed
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         clk0_meta_q <= PIN_IDLE[PIN_CLK];
         clk0_sync_q <= PIN_IDLE[PIN_CLK];
      end else begin
         clk0_meta_q <= elem_clk[0];
         clk0_sync_q <= clk0_meta_q;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         set0_meta_q <= PIN_IDLE[PIN_SET];
         set0_sync_q <= PIN_IDLE[PIN_SET];
      end else begin
         set0_meta_q <= set_req[0];
         set0_sync_q <= set0_meta_q;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rst0_meta_q <= PIN_IDLE[PIN_RST];
         rst0_sync_q <= PIN_IDLE[PIN_RST];
      end else begin
         rst0_meta_q <= rst_req[0];
         rst0_sync_q <= rst0_meta_q;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         preset_n0_meta_q <= PIN_IDLE[PIN_PRESET_N];
         preset_n0_sync_q <= PIN_IDLE[PIN_PRESET_N];
      end else begin
         preset_n0_meta_q <= preset_n[0];
         preset_n0_sync_q <= preset_n0_meta_q;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         clear_n0_meta_q <= PIN_IDLE[PIN_CLEAR_N];
         clear_n0_sync_q <= PIN_IDLE[PIN_CLEAR_N];
      end else begin
         clear_n0_meta_q <= clear_n[0];
         clear_n0_sync_q <= clear_n0_meta_q;
      end
   end

   // History starts low, so a clock already low at release is no edge
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         clk0_prev_q <= CLK_PREV_RESET;
      end else begin
         clk0_prev_q <= clk0_sync_q;
      end
   end

   // A fall needs a high level first; requests present at the sampled fall commit here
   assign link0.fall = clk0_prev_q & ~clk0_sync_q;
   // Requests are read at the sampled fall; the driver must hold them there
   assign link0.set_req = set0_sync_q;
   assign link0.rst_req = rst0_sync_q;
   assign link0.preset = ~preset_n0_sync_q;
   assign link0.clear = ~clear_n0_sync_q;

   // Element applies hold, clear, set or toggle on the fall pulse
   jk_element u_elem0 (
      .core_clk(core_clk),
      .resetn(resetn),
      .link(link0)
   );

   // Registered copy keeps the top output straight from a flop
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state0_q <= STATE_RESET;
      end else begin
         state0_q <= link0.previous_state;
      end
   end

   // Second element mirrors the first on its own pins; no input is shared
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         clk1_meta_q <= PIN_IDLE[PIN_CLK];
         clk1_sync_q <= PIN_IDLE[PIN_CLK];
      end else begin
         clk1_meta_q <= elem_clk[1];
         clk1_sync_q <= clk1_meta_q;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         set1_meta_q <= PIN_IDLE[PIN_SET];
         set1_sync_q <= PIN_IDLE[PIN_SET];
      end else begin
         set1_meta_q <= set_req[1];
         set1_sync_q <= set1_meta_q;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rst1_meta_q <= PIN_IDLE[PIN_RST];
         rst1_sync_q <= PIN_IDLE[PIN_RST];
      end else begin
         rst1_meta_q <= rst_req[1];
         rst1_sync_q <= rst1_meta_q;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         preset_n1_meta_q <= PIN_IDLE[PIN_PRESET_N];
         preset_n1_sync_q <= PIN_IDLE[PIN_PRESET_N];
      end else begin
         preset_n1_meta_q <= preset_n[1];
         preset_n1_sync_q <= preset_n1_meta_q;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         clear_n1_meta_q <= PIN_IDLE[PIN_CLEAR_N];
         clear_n1_sync_q <= PIN_IDLE[PIN_CLEAR_N];
      end else begin
         clear_n1_meta_q <= clear_n[1];
         clear_n1_sync_q <= clear_n1_meta_q;
      end
   end

   // Same low start for the second clock history
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         clk1_prev_q <= CLK_PREV_RESET;
      end else begin
         clk1_prev_q <= clk1_sync_q;
      end
   end

   // Fall pulse only after a seen high level
   assign link1.fall = clk1_prev_q & ~clk1_sync_q;
   // Requests taken from the same stage as the clock that showed the fall
   assign link1.set_req = set1_sync_q;
   assign link1.rst_req = rst1_sync_q;
   assign link1.preset = ~preset_n1_sync_q;
   assign link1.clear = ~clear_n1_sync_q;

   // Own element instance, own clock domain of events
   jk_element u_elem1 (
      .core_clk(core_clk),
      .resetn(resetn),
      .link(link1)
   );

   // Output flop for the second element
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state1_q <= STATE_RESET;
      end else begin
         state1_q <= link1.previous_state;
      end
   end

   // Both bits come straight from their output flops
   assign state = {state1_q, state0_q};

endmodule

//--- dv/jk_assertions.sv
// Port-level checks for the dual J-K block.
// Assumes requests stay put from two cycles before a fall.
`timescale 1ns/1ps
module jk_assertions (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [1:0] elem_clk,
   input wire logic [1:0] set_req,
   input wire logic [1:0] rst_req,
   input wire logic [1:0] preset_n,
   input wire logic [1:0] clear_n,
   input wire logic [1:0] state
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   wire logic free0 = preset_n[0] && clear_n[0];
   wire logic free1 = preset_n[1] && clear_n[1];
   toggle_elem_a: assert property ($fell(elem_clk[0]) && set_req[0] && rst_req[0] && free0 |->
      ##4 state[0] != $past(state[0], 4)) else $error("toggle missed");
   set_elem_a: assert property ($fell(elem_clk[1]) && set_req[1] && !rst_req[1] && free1 |-> ##4 state[1])
      else $error("set missed");
   clear_elem_a: assert property ($fell(elem_clk[0]) && !set_req[0] && rst_req[0] && free0 |-> ##4 !state[0])
      else $error("clear missed");
   preset_force_a: assert property ($fell(preset_n[0]) ##1 !preset_n[0] [*4] |-> state[0])
      else $error("preset not forcing");
   clear_force_a: assert property ($fell(clear_n[1]) && preset_n[1]
      ##1 (!clear_n[1] && preset_n[1]) [*4] |-> !state[1]) else $error("clear not forcing");
   quiet_first_a: assert property ((!$fell(elem_clk[0]) && free0) [*6] |=> $stable(state[0]))
      else $error("first state moved");
   quiet_second_a: assert property ((!$fell(elem_clk[1]) && free1) [*6] |=> $stable(state[1]))
      else $error("second state moved");
   cover property ($fell(elem_clk[0]) && set_req[0] && rst_req[0] && free0);
   cover property ($fell(elem_clk[1]) && !free1);
   cover property (!preset_n[0] && !clear_n[0]);
endmodule

//--- dv/jk_source.sv
// Model of the logic driving both element clocks and requests.
// Assumes fire pulses for one cycle, at most once per 12 cycles.
`timescale 1ns/1ps
module jk_source (
   input wire logic core_clk,
   input wire logic [1:0] fire,
   input wire logic [1:0] j,
   input wire logic [1:0] k,
   output logic [1:0] elem_clk = 2'h0,
   output logic [1:0] set_req = 2'h0,
   output logic [1:0] rst_req = 2'h0
);
   logic [3:0] n_q = 4'h0;
   logic [1:0] en_q = 2'h0;
   always_ff @(posedge core_clk) begin
      if (|fire) begin
         n_q <= 4'h9;
         en_q <= fire;
      end else if (n_q != 4'h0) n_q <= n_q - 4'h1;
      elem_clk <= (n_q > 4'h1) ? en_q : 2'h0;
      // Requests wander early in the high phase, then settle before the fall
      {set_req, rst_req} <= (n_q > 4'h6) ? 4'($urandom) : {j, k};
   end
endmodule

//--- dv/tb.sv
// Bench for the dual J-K block driven through the request source model.
// Assumes one operation at a time, settled within 24 cycles.
`timescale 1ns/1ps
module tb;
   logic core_clk = 1'h0;
   logic resetn = 1'h0;
   logic [1:0] fire = 2'h0, j = 2'h0, k = 2'h0, preset_n = 2'h3, clear_n = 2'h3;
   logic [1:0] elem_clk, set_req, rst_req, state, n, exp_q = 2'h0;
   logic [1:0] note_q[$];
   int err_count = 0, check_count = 0;
   initial forever #5 core_clk = ~core_clk;
   jk_source src (.core_clk, .fire, .j, .k, .elem_clk, .set_req, .rst_req);
   dual_jk_flipflop dut (.core_clk, .resetn, .elem_clk, .set_req, .rst_req, .preset_n, .clear_n, .state);
   task automatic conclude();
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic op(input logic [1:0] f, input logic [1:0] pn, input logic [1:0] cn);
      logic [1:0] jj, kk;
      jj = 2'($urandom);
      kk = 2'($urandom);
      @(posedge core_clk);
      fire <= f;
      j <= jj;
      k <= kk;
      preset_n <= pn;
      clear_n <= cn;
      exp_q = (jj & ~exp_q | ~kk & exp_q) & f | exp_q & ~f;
      exp_q = ~pn | exp_q & cn;
      note_q.push_back(exp_q);
      @(posedge core_clk);
      fire <= 2'h0;
      repeat (22) @(posedge core_clk);
   endtask
   initial forever begin
      @(negedge (|elem_clk));
      repeat (6) @(posedge core_clk);
      #1;
      n = note_q.pop_front();
      check_count++;
      if (state !== n) begin
         err_count++;
         $display("BAD state expected %b seen %b", n, state);
      end
   end
   initial begin
      repeat (3000) @(posedge core_clk);
      err_count++;
      conclude();
   end
   initial begin
      void'($urandom(32'h91a37d26));
      repeat (4) @(posedge core_clk);
      resetn <= 1'h1;
      for (int i = 0; i < 60; i++) begin
         op(2'($urandom_range(3, 1)), $urandom_range(3) ? 2'h3 : 2'($urandom),
            $urandom_range(3) ? 2'h3 : 2'($urandom));
      end
      conclude();
   end
endmodule
bind dual_jk_flipflop jk_assertions chk (.core_clk, .resetn, .elem_clk, .set_req, .rst_req, .preset_n,
   .clear_n, .state);
